// ===== hdl/p2g_port.sv
// Port-2 GPIO with top-pin function selection and APB register access
`timescale 1ns/1ps
// How it works
// [RQ1] Eight two-way pins, shared with pulse, timer and eight-bit timer signals.
// [RQ2] In GPIO mode direction 1 drives the pin, direction 0 makes it input.
// [RQ3] Direction register is write-only; reading it returns an undefined value.
// [RQ4] Output latch is read/write and drives pins only in GPIO mode.
// [RQ5] Pin-state read returns latch value where direction bit is 1.
// [RQ6] Pin-state read returns sampled pin level where direction bit is 0.
// [RQ7] Pin-state register is read-only and its reset value follows the pins; the code clears the pin sample to zero at reset.
// [RQ8] Timer compare-B output function overrides direction and pulse enable on top pin.
// [RQ9] Otherwise direction 0 input, 1 with enable 0 output, 1 with 1 pulse.
// [RQ10] Top pin feeds timer capture B in mode 0000 or 01xx with IO top 1.
// [RQ11] Normal/phase modes: IO 0001-0011, 0101-0111 give compare drive; else port.
// [RQ12] PWM mode 1 never lets the timer drive the top pin.
// [RQ13] PWM mode 2 drives only if IO not xx00 and clear select not 10.
// [RQ14] Software keeps a shadow of the direction register for read-modify-write.
// [RQ15] Direction and latch reset to zero, so all pins start as inputs.
module p2g_port (
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Port pins
    input  wire logic [7:0]  i_pin,
    output logic      [7:0]  o_pin,
    output logic      [7:0]  o_pin_oe,
    // Peripheral signals sharing the pins
    input  wire logic [7:0]  i_pulse_pattern_out,
    input  wire logic [6:0]  i_alt_out,
    input  wire logic [6:0]  i_alt_oe,
    input  wire logic        i_timer5_compare_b_out,
    output logic             o_timer5_compare_b_in,
    output logic             o_timer5_compare_b_capture_en
);

    // ****************************************************************
    // Registers and decode
    // ****************************************************************
    logic [7:0] pin_direction_reg;
    logic [7:0] pin_output_latch_reg;
    logic [3:0] timer_mode_field;
    logic [3:0] compare_b_io_field;
    logic [1:0] counter_clear_select;
    logic [7:0] pulse_output_enable_low_reg;
    logic [7:0] pin_sample;
    logic [7:0] pin_level_view;
    logic       wr_en;
    logic       rd_en;
    logic       timer_drives_top;
    logic       capture_sel;
    logic       addr_hit;
    p2g_pkg::p2g_function_type top_function;

    // Checks a register offset against the bus address
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction : addr_is

    // Access phase strobes; slave answers with no wait state
    assign wr_en    = i_psel && i_penable && i_pwrite;
    assign rd_en    = i_psel && i_penable && !i_pwrite;
    assign o_pready = 1'b1;
    assign addr_hit = addr_is(i_paddr, p2g_pkg::PIN_DIRECTION_OFS)
                   || addr_is(i_paddr, p2g_pkg::PIN_OUTPUT_LATCH_OFS)
                   || addr_is(i_paddr, p2g_pkg::PIN_LEVEL_OFS)
                   || addr_is(i_paddr, p2g_pkg::TIMER5_MODE_OFS)
                   || addr_is(i_paddr, p2g_pkg::TIMER5_IO_OFS)
                   || addr_is(i_paddr, p2g_pkg::TIMER5_CONTROL_OFS)
                   || addr_is(i_paddr, p2g_pkg::PULSE_ENABLE_OFS);
    // Unmapped address gives an error; writing the pin-state register is just ignored
    assign o_pslverr = i_psel && i_penable && !addr_hit;

    // ****************************************************************
    // Direction register
    // ****************************************************************
    // Write-only, cleared at reset
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_direction_reg <= p2g_pkg::DIRECTION_RESET; // see [RQ15]
        end else if (wr_en && i_pstrb[0]
                     && addr_is(i_paddr, p2g_pkg::PIN_DIRECTION_OFS)) begin
            pin_direction_reg <= i_pwdata[7:0]; // see [RQ2]
        end
    end

    // Output latch register, cleared at reset
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_output_latch_reg <= p2g_pkg::OUTPUT_LATCH_RESET; // see [RQ15]
        end else if (wr_en && i_pstrb[0]
                     && addr_is(i_paddr, p2g_pkg::PIN_OUTPUT_LATCH_OFS)) begin
            pin_output_latch_reg <= i_pwdata[7:0]; // see [RQ4]
        end
    end

    // Timer channel 5 settings and pulse enables that steer the top pin
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            timer_mode_field            <= p2g_pkg::TIMER_FIELD_RESET;
            compare_b_io_field          <= p2g_pkg::TIMER_FIELD_RESET;
            counter_clear_select        <= p2g_pkg::CLEAR_SELECT_RESET;
            pulse_output_enable_low_reg <= p2g_pkg::PULSE_ENABLE_RESET;
        end else if (wr_en && i_pstrb[0]) begin
            if (addr_is(i_paddr, p2g_pkg::TIMER5_MODE_OFS)) begin
                timer_mode_field <= i_pwdata[3:0];
            end
            if (addr_is(i_paddr, p2g_pkg::TIMER5_IO_OFS)) begin
                compare_b_io_field <= i_pwdata[3:0];
            end
            if (addr_is(i_paddr, p2g_pkg::TIMER5_CONTROL_OFS)) begin
                counter_clear_select <= i_pwdata[p2g_pkg::CLEAR_FIELD_LSB +: 2];
            end
            if (addr_is(i_paddr, p2g_pkg::PULSE_ENABLE_OFS)) begin
                pulse_output_enable_low_reg <= i_pwdata[7:0];
            end
        end
    end

    // Pin sample register; cleared to zero at reset, then samples the pins every clock
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_sample <= 8'h00;
        end else begin
            pin_sample <= i_pin; // see [RQ7]
        end
    end

    // Per-bit mix of latch and pin level
    assign pin_level_view = (pin_direction_reg & pin_output_latch_reg)
                          | (~pin_direction_reg & pin_sample); // see [RQ5] see [RQ6]

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            unique case (i_paddr)
                p2g_pkg::PIN_DIRECTION_OFS:    o_prdata <= p2g_pkg::UNDEFINED_READ_VALUE; // see [RQ3]
                p2g_pkg::PIN_OUTPUT_LATCH_OFS: o_prdata <= {24'h00_0000, pin_output_latch_reg};
                p2g_pkg::PIN_LEVEL_OFS:        o_prdata <= {24'h00_0000, pin_level_view};
                p2g_pkg::TIMER5_MODE_OFS:      o_prdata <= {28'h000_0000, timer_mode_field};
                p2g_pkg::TIMER5_IO_OFS:        o_prdata <= {28'h000_0000, compare_b_io_field};
                p2g_pkg::TIMER5_CONTROL_OFS:
                    o_prdata <= {25'h000_0000, counter_clear_select, 5'h00};
                p2g_pkg::PULSE_ENABLE_OFS:     o_prdata <= {24'h00_0000, pulse_output_enable_low_reg};
                default:                       o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Top pin function selection
    // ****************************************************************
    // Decides when timer channel 5 owns the top pin
    always_comb begin
        timer_drives_top = 1'b0;
        if (timer_mode_field == p2g_pkg::MODE_NORMAL
            || (timer_mode_field & p2g_pkg::MODE_PHASE_MASK) == p2g_pkg::MODE_PHASE_CODE) begin
            timer_drives_top = !compare_b_io_field[p2g_pkg::IO_FIELD_TOP_BIT]
                            && (compare_b_io_field[1:0] != 2'b00); // see [RQ11]
        end else if (timer_mode_field == p2g_pkg::MODE_PWM1) begin
            timer_drives_top = 1'b0; // see [RQ12]
        end else if (timer_mode_field == p2g_pkg::MODE_PWM2) begin
            timer_drives_top = (compare_b_io_field[1:0] != 2'b00)
                            && (counter_clear_select != p2g_pkg::PWM2_CLEAR_BLOCK); // see [RQ13]
        end
    end

    // Priority: timer, then direction, then pulse enable
    always_comb begin
        if (timer_drives_top) begin
            top_function = p2g_pkg::P2G_FN_TIMER; // see [RQ8]
        end else if (!pin_direction_reg[p2g_pkg::TOP_PIN_INDEX]) begin
            top_function = p2g_pkg::P2G_FN_INPUT; // see [RQ9]
        end else if (pulse_output_enable_low_reg[p2g_pkg::TOP_PIN_INDEX]) begin
            top_function = p2g_pkg::P2G_FN_PULSE; // see [RQ9]
        end else begin
            top_function = p2g_pkg::P2G_FN_OUTPUT;
        end
    end

    // Capture input routing for the top pin
    assign capture_sel = (timer_mode_field == p2g_pkg::MODE_NORMAL
                          || (timer_mode_field & p2g_pkg::MODE_PHASE_MASK)
                             == p2g_pkg::MODE_PHASE_CODE)
                         && compare_b_io_field[p2g_pkg::IO_FIELD_TOP_BIT]; // see [RQ10]
    assign o_timer5_compare_b_capture_en = capture_sel;
    assign o_timer5_compare_b_in         = pin_sample[p2g_pkg::TOP_PIN_INDEX];

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    // Lower pins: peripheral, pulse, or GPIO by direction
    genvar g;
    generate
        for (g = 0; g < p2g_pkg::TOP_PIN_INDEX; g++) begin : g_low_pin
            always_comb begin
                if (i_alt_oe[g]) begin
                    o_pin[g]    = i_alt_out[g]; // see [RQ1]
                    o_pin_oe[g] = 1'b1;
                end else if (pin_direction_reg[g] && pulse_output_enable_low_reg[g]) begin
                    o_pin[g]    = i_pulse_pattern_out[g];
                    o_pin_oe[g] = 1'b1;
                end else begin
                    o_pin[g]    = pin_output_latch_reg[g]; // see [RQ4]
                    o_pin_oe[g] = pin_direction_reg[g]; // see [RQ2]
                end
            end
        end
    endgenerate

    // Top pin driven from the selected owner
    always_comb begin
        unique case (top_function)
            p2g_pkg::P2G_FN_TIMER: begin
                o_pin[7]    = i_timer5_compare_b_out;
                o_pin_oe[7] = 1'b1;
            end
            p2g_pkg::P2G_FN_PULSE: begin
                o_pin[7]    = i_pulse_pattern_out[7];
                o_pin_oe[7] = 1'b1;
            end
            p2g_pkg::P2G_FN_OUTPUT: begin
                o_pin[7]    = pin_output_latch_reg[7]; // see [RQ2]
                o_pin_oe[7] = 1'b1;
            end
            p2g_pkg::P2G_FN_INPUT: begin
                o_pin[7]    = pin_output_latch_reg[7];
                o_pin_oe[7] = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_timer_owns_top: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        timer_drives_top |-> (o_pin_oe[7] && o_pin[7] == i_timer5_compare_b_out)) // see [RQ8]
        else $error("timer does not own top pin");
    a_pwm1_no_timer: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        timer_mode_field == p2g_pkg::MODE_PWM1 |-> !timer_drives_top) // see [RQ12]
        else $error("timer drives top pin in pwm1");
    a_pwm2_block: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (timer_mode_field == p2g_pkg::MODE_PWM2 && counter_clear_select == 2'h2)
        |-> !timer_drives_top) // see [RQ13]
        else $error("pwm2 drive with blocked clear");
    a_input_top_idle: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (!timer_drives_top && !pin_direction_reg[7]) |-> !o_pin_oe[7]) // see [RQ9]
        else $error("top input pin driven");
    a_level_input: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        ($past(i_reset_n) && !pin_direction_reg[0] && $stable(pin_direction_reg))
        |-> pin_level_view[0] == $past(i_pin[0])) // see [RQ6]
        else $error("pin level view wrong");
    a_level_output: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        pin_direction_reg[1] |-> pin_level_view[1] == pin_output_latch_reg[1]) // see [RQ5]
        else $error("latch not reflected");
    a_dir_reads_undef: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (rd_en && i_paddr == p2g_pkg::PIN_DIRECTION_OFS)
        |-> o_prdata == p2g_pkg::UNDEFINED_READ_VALUE) // see [RQ3]
        else $error("direction read back");
    a_latch_write: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (wr_en && i_pstrb[0] && i_paddr == p2g_pkg::PIN_OUTPUT_LATCH_OFS)
        |=> pin_output_latch_reg == $past(i_pwdata[7:0])) // see [RQ4]
        else $error("latch write lost");
    a_gpio_drive: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (!i_alt_oe[2] && !pulse_output_enable_low_reg[2])
        |-> o_pin_oe[2] == pin_direction_reg[2]) // see [RQ2]
        else $error("gpio enable mismatch");
    a_capture_route: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (timer_mode_field == 4'h4 && compare_b_io_field[3]) |-> capture_sel) // see [RQ10]
        else $error("capture not routed");

    c_timer_top: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        top_function == p2g_pkg::P2G_FN_TIMER);
    c_pulse_top: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        top_function == p2g_pkg::P2G_FN_PULSE);
    c_level_read: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        rd_en && i_paddr == p2g_pkg::PIN_LEVEL_OFS);

endmodule : p2g_port

// ===== shared/p2g_pkg.sv
// Package of register offsets, field positions and mode codes for the port-2 GPIO block
package p2g_pkg;

    // ****************************************************************
    // Register map (byte addresses on APB)
    // ****************************************************************
    localparam logic [11:0] PIN_DIRECTION_OFS    = 12'h000;
    localparam logic [11:0] PIN_OUTPUT_LATCH_OFS = 12'h004;
    localparam logic [11:0] PIN_LEVEL_OFS        = 12'h008;
    localparam logic [11:0] TIMER5_MODE_OFS      = 12'h00C;
    localparam logic [11:0] TIMER5_IO_OFS        = 12'h010;
    localparam logic [11:0] TIMER5_CONTROL_OFS   = 12'h014;
    localparam logic [11:0] PULSE_ENABLE_OFS     = 12'h018;

    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int          PORT_WIDTH           = 8;
    localparam logic [7:0]  DIRECTION_RESET      = 8'h00;
    localparam logic [7:0]  OUTPUT_LATCH_RESET   = 8'h00;
    localparam logic [3:0]  TIMER_FIELD_RESET    = 4'h0;
    localparam logic [1:0]  CLEAR_SELECT_RESET   = 2'h0;
    localparam logic [7:0]  PULSE_ENABLE_RESET   = 8'h00;
    // Value returned when the write-only direction register is read (arbitrary)
    localparam logic [31:0] UNDEFINED_READ_VALUE = 32'h0000_0000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int          TOP_PIN_INDEX        = 7;
    localparam int          IO_FIELD_TOP_BIT     = 3;
    localparam int          CLEAR_FIELD_LSB      = 5;

    // ****************************************************************
    // Timer mode field codes
    // ****************************************************************
    localparam logic [3:0]  MODE_NORMAL          = 4'h0;
    localparam logic [3:0]  MODE_PWM1            = 4'h2;
    localparam logic [3:0]  MODE_PWM2            = 4'h3;
    localparam logic [3:0]  MODE_PHASE_MASK      = 4'hC;
    localparam logic [3:0]  MODE_PHASE_CODE      = 4'h4;
    localparam logic [1:0]  PWM2_CLEAR_BLOCK     = 2'h2;

    // Top pin owner encoding
    typedef enum logic [1:0] {
        P2G_FN_INPUT  = 2'b00,
        P2G_FN_OUTPUT = 2'b01,
        P2G_FN_PULSE  = 2'b10,
        P2G_FN_TIMER  = 2'b11
    } p2g_function_type;

endpackage : p2g_pkg

// ===== bench/p2g_board.sv
// Board-side model of the eight port pins
`timescale 1ns/1ps
module p2g_board (
    // Board drive and device pin outputs
    input  wire logic [7:0] i_level_drive,
    input  wire logic [7:0] i_pin_out,
    input  wire logic [7:0] i_pin_oe,
    // Resolved pin levels
    output logic      [7:0] o_pin_level
);
    // ****************************************************************
    // Pin resolution
    // ****************************************************************
    // Device drive wins where enabled, board drive elsewhere
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            o_pin_level[b] = i_pin_oe[b] ? i_pin_out[b] : i_level_drive[b];
        end
    end
endmodule : p2g_board

// ===== bench/p2g_tb.sv
// Self-checking testbench for the port-2 GPIO block
`timescale 1ns/1ps
module testbench;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, err, tmr_out = 0, cap_in, cap_en;
    logic [7:0]  pin_lvl, pin_out, pin_oe, drive = 8'h00, pulse = 8'h00;
    logic [6:0]  alt_out = 7'h00, alt_oe = 7'h00;
    int          n_fail = 0, n_tests = 0;
    logic [7:0]  dir_shadow = 8'h00; // Software copy of the write-only direction register
    // Mode, io, clear select, then drive and capture flags
    logic [15:0] tbl [16] = '{16'h0000, 16'h0102, 16'h0302, 16'h0400, 16'h0502,
        16'h0702, 16'h0801, 16'h4202, 16'h4901, 16'h2100, 16'h2800, 16'h3102,
        16'h3400, 16'h3120, 16'h3132, 16'h8100};

    // Clock
    always #2 clk = ~clk;

    // ****************************************************************
    // Instances
    // ****************************************************************
    p2g_port i_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(4'h1), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_pin(pin_lvl), .o_pin(pin_out), .o_pin_oe(pin_oe),
        .i_pulse_pattern_out(pulse), .i_alt_out(alt_out), .i_alt_oe(alt_oe),
        .i_timer5_compare_b_out(tmr_out), .o_timer5_compare_b_in(cap_in),
        .o_timer5_compare_b_capture_en(cap_en));
    p2g_board i_board (.i_level_drive(drive), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
        .o_pin_level(pin_lvl));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One APB transfer, waiting on pready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 50) begin
            n_fail++;
            give_verdict();
        end
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Reset values and write-only direction read
    task automatic t_reset();
        check("oe after reset", {24'h0, pin_oe}, 32'h0000_0000);
        apb(0, p2g_pkg::PIN_OUTPUT_LATCH_OFS, 0);
        check("latch reset", rd, 32'h0000_0000);
        apb(1, p2g_pkg::PIN_DIRECTION_OFS, 32'h0000_00FF);
        apb(0, p2g_pkg::PIN_DIRECTION_OFS, 0);
        check("direction read", rd, p2g_pkg::UNDEFINED_READ_VALUE);
        apb(0, 12'h0FC, 0);
        check("unmapped error", {31'h0, err}, 32'h0000_0001);
        $display("t_reset done");
    endtask : t_reset

    // Direction, latch, pin-level mix and read-only level register
    task automatic t_gpio();
        drive <= 8'h3C;
        apb(1, p2g_pkg::PIN_DIRECTION_OFS, 32'h0000_00F0);
        apb(1, p2g_pkg::PIN_OUTPUT_LATCH_OFS, 32'h0000_00A5);
        @(posedge clk);
        check("oe gpio", {24'h0, pin_oe}, 32'h0000_00F0);
        check("pin out", {28'h0, pin_out[7:4]}, 32'h0000_000A);
        apb(0, p2g_pkg::PIN_LEVEL_OFS, 0);
        check("level mix", rd, 32'h0000_00AC);
        apb(1, p2g_pkg::PIN_LEVEL_OFS, 32'h0000_0000);
        apb(0, p2g_pkg::PIN_LEVEL_OFS, 0);
        check("level ro", rd, 32'h0000_00AC);
        apb(0, p2g_pkg::PIN_OUTPUT_LATCH_OFS, 0);
        check("latch kept", rd, 32'h0000_00A5);
        $display("t_gpio done");
    endtask : t_gpio

    // Latch read while another source drives the pin, plus pulse output
    task automatic t_override();
        alt_out <= 7'h01; alt_oe <= 7'h01; tmr_out <= 1'b0;
        dir_shadow = 8'h81;
        apb(1, p2g_pkg::PIN_DIRECTION_OFS, {24'h0, dir_shadow});
        apb(1, p2g_pkg::PIN_OUTPUT_LATCH_OFS, 32'h0000_0080);
        apb(1, p2g_pkg::TIMER5_IO_OFS, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check("alt pin0", {30'h0, pin_oe[0], pin_out[0]}, 32'h0000_0003);
        check("timer pin7", {31'h0, pin_out[7]}, 32'h0000_0000);
        apb(0, p2g_pkg::PIN_LEVEL_OFS, 0);
        check("level latch", rd & 32'h0000_0081, 32'h0000_0080);
        apb(1, p2g_pkg::TIMER5_IO_OFS, 32'h0000_0000);
        apb(1, p2g_pkg::PULSE_ENABLE_OFS, 32'h0000_0080);
        pulse <= 8'h00;
        @(posedge clk);
        check("pulse pin7", {30'h0, pin_oe[7], pin_out[7]}, 32'h0000_0002);
        apb(1, p2g_pkg::PULSE_ENABLE_OFS, 32'h0000_0000);
        @(posedge clk);
        check("gpio pin7", {30'h0, pin_oe[7], pin_out[7]}, 32'h0000_0003);
        // Read-modify-write of the shadow turns only the top pin back to input
        dir_shadow[7] = 1'b0;
        apb(1, p2g_pkg::PIN_DIRECTION_OFS, {24'h0, dir_shadow});
        @(posedge clk);
        check("rmw top input", {30'h0, pin_oe[7], pin_oe[0]}, 32'h0000_0001);
        alt_oe <= 7'h00;
        $display("t_override done");
    endtask : t_override

    // Timer ownership and capture routing over mode, io and clear settings
    task automatic t_timer();
        logic [15:0] e;
        tmr_out <= 1'b1; drive <= 8'h80;
        apb(1, p2g_pkg::PIN_DIRECTION_OFS, 32'h0000_0000);
        foreach (tbl[i]) begin
            e = tbl[i];
            apb(1, p2g_pkg::TIMER5_MODE_OFS, {28'h0, e[15:12]});
            apb(1, p2g_pkg::TIMER5_IO_OFS, {28'h0, e[11:8]});
            apb(1, p2g_pkg::TIMER5_CONTROL_OFS, {25'h0, e[5:4], 5'h00});
            repeat (2) @(posedge clk);
            check("timer own", {31'h0, pin_oe[7]}, {31'h0, e[1]});
            check("capture en", {31'h0, cap_en}, {31'h0, e[0]});
            check("capture in", {31'h0, cap_in}, 32'h0000_0001);
        end
        $display("t_timer done");
    endtask : t_timer

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_gpio();
        t_override();
        t_timer();
        give_verdict();
    end
endmodule : testbench
